// ===== verilog/tsm_pkg.sv
// constants and carrier types for the timer sync and mode control block
package tsm_pkg;

  localparam int unsigned NUM_CH   = 5;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned ADDR_W   = 8;

  // register byte offsets
  localparam logic [7:0] OFS_SYNC   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_COMB   = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0C;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_CNT2   = 8'h14;

  // reset values
  localparam logic [7:0] SYNC_RST   = 8'hE0;
  localparam logic [7:0] MODE_RST   = 8'h80;
  localparam logic [1:0] COMB_RST   = 2'h0;
  localparam logic [1:0] IRQ_RST    = 2'h0;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  // fixed-one and writable masks
  localparam logic [7:0] SYNC_FIXED = 8'hE0;
  localparam logic [7:0] SYNC_WMASK = 8'h1F;
  localparam logic [7:0] MODE_FIXED = 8'h80;
  localparam logic [7:0] MODE_WMASK = 8'h7F;

  // field positions
  localparam int unsigned MODE_PHASE_BIT = 6;
  localparam int unsigned MODE_OVERFLOW_FLAG_CONDITION_BIT  = 5;
  localparam int unsigned COMB_HI_BIT    = 1;
  localparam int unsigned STAT_OVF_BIT   = 0;
  localparam int unsigned STAT_SYNC_BIT  = 1;
  localparam int unsigned CH_PHASE       = 2;
  localparam int unsigned CH_COMB_LO     = 3;
  localparam int unsigned CH_COMB_HI     = 4;

  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_MIN  = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  // preset and clear requests, one bit per channel
  typedef struct packed {
    logic [4:0] clear;
    logic [4:0] preset;
  } tsm_sync_evt_t;

  // phase decoder edge results
  typedef struct packed {
    logic up;
    logic down;
  } tsm_step_t;

endpackage

// ===== verilog/tsm_ctrl.sv
// timer channel synchronisation, mode select, phase counter and pwm pins
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - sync register loads 0xE0 on reset and on standby entry.
// - sync bits 7..5 ignore writes and read as one.
// - sync bit n puts channel n in synchronous operation; resets to zero.
// - synced channel preset/clear also hits every other synced channel.
// - unsynced channel affects only itself and ignores others' events.
// - mode register loads 0x80 on reset and on standby entry.
// - mode bit 7 is unwritable and reads as one.
// - phase mode counts every edge of both external clock inputs; here no count when both inputs change in one cycle.
// - phase mode ignores channel 2 edge and source clock selection.
// - phase mode keeps clear, compare, capture, flags and enables.
// - mode bit 5: zero flags overflow or underflow, one overflow only.
// - mode bit n selects pwm for channel n; resets to zero.
// - pwm: pin A set on compare A, cleared on compare B.
// - combination pwm modes override pwm bits of channels 3 and 4.
// - combination field upper bit zero normal, 10 complementary, 11 resync.
module tsm_ctrl (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // power state
  input  wire logic        standby_i,
  // channel requests and compare matches
  input  wire logic [4:0]  ch_clear_req_i,
  input  wire logic [4:0]  ch_preset_req_i,
  input  wire logic [4:0]  cmp_match_a_i,
  input  wire logic [4:0]  cmp_match_b_i,
  // channel 2 counter control
  input  wire logic        ch2_run_i,
  input  wire logic        ch2_tick_i,
  input  wire logic [15:0] ch2_preset_val_i,
  // external clock pins
  input  wire logic        ext_clock_in_a_i,
  input  wire logic        ext_clock_in_b_i,
  // channel actions
  output logic      [4:0]  ch_clear_o,
  output logic      [4:0]  ch_preset_o,
  output logic      [15:0] counter_ch2_o,
  output logic      [1:0]  comb_mode_o,
  // pin A of each channel
  output logic      [4:0]  channel_pin_a_o,
  output logic      [4:0]  channel_pin_a_oe_o,
  // interrupt
  output logic             irq_o
);

  logic [7:0]           channel_sync_select_reg;
  logic [7:0]           timer_mode_select_reg;
  logic [1:0]           comb_mode_reg;
  logic [1:0]           irq_status_reg;
  logic [1:0]           irq_mask_reg;
  logic [15:0]          counter_ch2_reg;
  logic [31:0]          prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic                 irq_reg;
  tsm_pkg::tsm_sync_evt_t sync_evt_reg;
  tsm_pkg::tsm_sync_evt_t sync_evt_next;
  logic [4:0]           pin_a_reg;
  logic [4:0]           pin_a_oe_reg;
  logic [4:0]           pwm_eff;
  logic [1:0]           a_sync_reg;
  logic [1:0]           b_sync_reg;
  logic                 a_prev_reg;
  logic                 b_prev_reg;
  tsm_pkg::tsm_step_t   step;
  logic                 phase_en;
  logic                 cnt_up;
  logic                 cnt_down;
  logic                 overflow_evt;
  logic                 underflow_evt;
  logic                 ovf_set;
  logic                 ch2_clear;
  logic                 ch2_preset;
  logic [1:0]           irq_events;
  logic                 acc;
  logic                 wr_en;
  logic                 mapped;
  logic [31:0]          rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state, so pready comes from a flop

  assign acc    = psel_i && penable_i;
  assign wr_en  = acc && pready_reg && pwrite_i && !pslverr_reg;
  assign mapped = (paddr_i == tsm_pkg::OFS_SYNC) ||
                  (paddr_i == tsm_pkg::OFS_MODE) ||
                  (paddr_i == tsm_pkg::OFS_COMB) ||
                  (paddr_i == tsm_pkg::OFS_STAT) ||
                  (paddr_i == tsm_pkg::OFS_MASK) ||
                  (paddr_i == tsm_pkg::OFS_CNT2);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      tsm_pkg::OFS_SYNC: rd_mux[7:0]   = channel_sync_select_reg;
      tsm_pkg::OFS_MODE: rd_mux[7:0]   = timer_mode_select_reg;
      tsm_pkg::OFS_COMB: rd_mux[1:0]   = comb_mode_reg;
      tsm_pkg::OFS_STAT: rd_mux[1:0]   = irq_status_reg;
      tsm_pkg::OFS_MASK: rd_mux[1:0]   = irq_mask_reg;
      tsm_pkg::OFS_CNT2: rd_mux[15:0]  = counter_ch2_reg;
      default:           rd_mux        = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc && !pready_reg;
      pslverr_reg <= acc && !pready_reg && !mapped;
      if (acc && !pready_reg) begin
        prdata_reg <= (mapped && !pwrite_i) ? rd_mux : 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  // sync register reset and standby load
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      channel_sync_select_reg <= tsm_pkg::SYNC_RST;
    end else if (standby_i) begin
      channel_sync_select_reg <= tsm_pkg::SYNC_RST;
    end else if (wr_en && paddr_i == tsm_pkg::OFS_SYNC) begin
      // only sync bits take the write
      channel_sync_select_reg <= tsm_pkg::SYNC_FIXED |
                                 (pwdata_i[7:0] & tsm_pkg::SYNC_WMASK);
    end
  end

  // mode register reset and standby load
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_mode_select_reg <= tsm_pkg::MODE_RST;
    end else if (standby_i) begin
      timer_mode_select_reg <= tsm_pkg::MODE_RST;
    end else if (wr_en && paddr_i == tsm_pkg::OFS_MODE) begin
      timer_mode_select_reg <= tsm_pkg::MODE_FIXED |
                               (pwdata_i[7:0] & tsm_pkg::MODE_WMASK);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comb_mode_reg <= tsm_pkg::COMB_RST;
    end else if (standby_i) begin
      comb_mode_reg <= tsm_pkg::COMB_RST;
    end else if (wr_en && paddr_i == tsm_pkg::OFS_COMB) begin
      comb_mode_reg <= pwdata_i[1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_reg <= tsm_pkg::IRQ_RST;
    end else if (standby_i) begin
      irq_mask_reg <= tsm_pkg::IRQ_RST;
    end else if (wr_en && paddr_i == tsm_pkg::OFS_MASK) begin
      irq_mask_reg <= pwdata_i[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // synchronous preset and clear fan-out

  always_comb begin
    sync_evt_next = '0;
    for (int k = 0; k < tsm_pkg::NUM_CH; k++) begin
      // own request, plus shared ones only when synced
      sync_evt_next.clear[k]  = ch_clear_req_i[k] ||
        (channel_sync_select_reg[k] &&
         |(ch_clear_req_i & channel_sync_select_reg[4:0]));
      sync_evt_next.preset[k] = ch_preset_req_i[k] ||
        (channel_sync_select_reg[k] &&
         |(ch_preset_req_i & channel_sync_select_reg[4:0]));
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_evt_reg <= '0;
    end else begin
      sync_evt_reg <= sync_evt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel 2 phase decoder and counter

  // pins are asynchronous: two flops before any logic
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_sync_reg <= 2'b00;
      b_sync_reg <= 2'b00;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_sync_reg <= {a_sync_reg[0], ext_clock_in_a_i};
      b_sync_reg <= {b_sync_reg[0], ext_clock_in_b_i};
      a_prev_reg <= a_sync_reg[1];
      b_prev_reg <= b_sync_reg[1];
    end
  end

  // every edge of either input, direction from the other level
  always_comb begin
    step.down = (a_sync_reg[1] && !a_prev_reg && !b_sync_reg[1]) ||
                (b_sync_reg[1] && !b_prev_reg &&  a_sync_reg[1]) ||
                (!a_sync_reg[1] && a_prev_reg &&  b_sync_reg[1]) ||
                (!b_sync_reg[1] && b_prev_reg && !a_sync_reg[1]);
    step.up   = (a_sync_reg[1] && !a_prev_reg &&  b_sync_reg[1]) ||
                (b_sync_reg[1] && !b_prev_reg && !a_sync_reg[1]) ||
                (!a_sync_reg[1] && a_prev_reg && !b_sync_reg[1]) ||
                (!b_sync_reg[1] && b_prev_reg &&  a_sync_reg[1]);
  end

  // phase mode replaces the tick source entirely
  // both pins moving in one cycle is ambiguous, so no count then
  assign phase_en = timer_mode_select_reg[tsm_pkg::MODE_PHASE_BIT];
  assign cnt_up   = ch2_run_i &&
                    (phase_en ? (step.up && !step.down) : ch2_tick_i);
  assign cnt_down = ch2_run_i && phase_en && step.down && !step.up;

  // clear and preset stay effective in phase mode
  assign ch2_clear  = sync_evt_next.clear[tsm_pkg::CH_PHASE];
  assign ch2_preset = sync_evt_next.preset[tsm_pkg::CH_PHASE];

  assign overflow_evt  = !ch2_clear && !ch2_preset && cnt_up &&
                         counter_ch2_reg == tsm_pkg::CNT_MAX;
  assign underflow_evt = !ch2_clear && !ch2_preset && cnt_down &&
                         counter_ch2_reg == tsm_pkg::CNT_MIN;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_ch2_reg <= tsm_pkg::CNT_RST;
    end else if (ch2_clear) begin
      counter_ch2_reg <= tsm_pkg::CNT_RST;
    end else if (ch2_preset) begin
      counter_ch2_reg <= ch2_preset_val_i;
    end else if (cnt_up) begin
      counter_ch2_reg <= counter_ch2_reg + tsm_pkg::CNT_ONE;
    end else if (cnt_down) begin
      counter_ch2_reg <= counter_ch2_reg - tsm_pkg::CNT_ONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags and interrupt

  // underflow counts only while the condition bit is zero
  assign ovf_set = overflow_evt ||
    (underflow_evt && !timer_mode_select_reg[tsm_pkg::MODE_OVERFLOW_FLAG_CONDITION_BIT]);

  always_comb begin
    irq_events = 2'b00;
    irq_events[tsm_pkg::STAT_OVF_BIT]  = ovf_set;
    irq_events[tsm_pkg::STAT_SYNC_BIT] =
      |(sync_evt_next.clear & ~ch_clear_req_i);
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status_reg <= tsm_pkg::IRQ_RST;
    end else if (standby_i) begin
      irq_status_reg <= tsm_pkg::IRQ_RST;
    end else if (wr_en && paddr_i == tsm_pkg::OFS_STAT) begin
      irq_status_reg <= (irq_status_reg & ~pwdata_i[1:0]) | irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pwm pin A per channel

  genvar g;
  generate
    for (g = 0; g < tsm_pkg::NUM_CH; g++) begin : g_pwm
      // channels 3 and 4 yield to combination pwm
      if (g == tsm_pkg::CH_COMB_LO || g == tsm_pkg::CH_COMB_HI) begin : g_cmb
        assign pwm_eff[g] = timer_mode_select_reg[g] &&
                            !comb_mode_reg[tsm_pkg::COMB_HI_BIT];
      end else begin : g_pln
        assign pwm_eff[g] = timer_mode_select_reg[g];
      end

      // set on compare A, clear on compare B; B wins a tie
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pin_a_reg[g]    <= 1'b0;
          pin_a_oe_reg[g] <= 1'b0;
        end else begin
          pin_a_oe_reg[g] <= pwm_eff[g];
          if (!pwm_eff[g]) begin
            pin_a_reg[g] <= 1'b0;
          end else if (cmp_match_b_i[g]) begin
            pin_a_reg[g] <= 1'b0;
          end else if (cmp_match_a_i[g]) begin
            pin_a_reg[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o           = prdata_reg;
  assign pready_o           = pready_reg;
  assign pslverr_o          = pslverr_reg;
  assign ch_clear_o         = sync_evt_reg.clear;
  assign ch_preset_o        = sync_evt_reg.preset;
  assign counter_ch2_o      = counter_ch2_reg;
  assign comb_mode_o        = comb_mode_reg;
  assign channel_pin_a_o    = pin_a_reg;
  assign channel_pin_a_oe_o = pin_a_oe_reg;
  assign irq_o              = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sync_reserved_a: assert property (
    channel_sync_select_reg[7:5] == 3'b111)
    else $error("sync reserved bits not one");
  sync_standby_a: assert property (
    standby_i |=> channel_sync_select_reg == tsm_pkg::SYNC_RST)
    else $error("sync register not reloaded on standby");
  // pin enable trails the mode register by one cycle
  mode_standby_a: assert property (
    standby_i |=> timer_mode_select_reg == tsm_pkg::MODE_RST
                  ##1 !channel_pin_a_oe_o[0])
    else $error("mode register not reloaded on standby");
  mode_bit7_a: assert property (
    timer_mode_select_reg[7])
    else $error("mode bit 7 not one");
  sync_fanout_a: assert property (
    ch_clear_req_i[0] && channel_sync_select_reg[0] &&
    channel_sync_select_reg[1] |=> ch_clear_o[1])
    else $error("synced clear did not fan out");
  sync_isolate_a: assert property (
    !channel_sync_select_reg[1] && !ch_clear_req_i[1] &&
    !ch_preset_req_i[1] |=> !ch_clear_o[1] && !ch_preset_o[1])
    else $error("unsynced channel hit by other channel");
  phase_down_a: assert property (
    phase_en && ch2_run_i && step.down && !step.up &&
    !ch2_clear && !ch2_preset && counter_ch2_reg != tsm_pkg::CNT_MIN
    |=> counter_ch2_reg == $past(counter_ch2_reg) - tsm_pkg::CNT_ONE)
    else $error("phase down step wrong");
  phase_ignore_a: assert property (
    phase_en && !step.up && !step.down && !ch2_clear && !ch2_preset
    |=> $stable(counter_ch2_reg))
    else $error("phase mode counted tick source");
  ovf_cond_a: assert property (
    underflow_evt && timer_mode_select_reg[tsm_pkg::MODE_OVERFLOW_FLAG_CONDITION_BIT] &&
    !irq_status_reg[0] |=> !irq_status_reg[0])
    else $error("underflow flagged while overflow only");
  pwm_set_a: assert property (
    pwm_eff[0] && cmp_match_a_i[0] && !cmp_match_b_i[0]
    |=> channel_pin_a_o[0] && channel_pin_a_oe_o[0])
    else $error("pwm pin not set on compare A");
  comb_override_a: assert property (
    comb_mode_reg[tsm_pkg::COMB_HI_BIT]
    |=> !channel_pin_a_oe_o[3] && !channel_pin_a_oe_o[4])
    else $error("combination mode did not override pwm");

endmodule

// ===== test/tsm_ctrl_tb.sv
// self-checking bench for the timer sync and mode control block
`timescale 1ns/1ps

module tsm_ctrl_tb;
  logic        ref_clk_i;
  logic        rst_b_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        standby_i;
  logic [4:0]  ch_clear_req_i;
  logic [4:0]  ch_preset_req_i;
  logic [4:0]  cmp_match_a_i;
  logic [4:0]  cmp_match_b_i;
  logic        ch2_run_i;
  logic        ch2_tick_i;
  logic [15:0] ch2_preset_val_i;
  logic        ext_clock_in_a_i;
  logic        ext_clock_in_b_i;
  logic [4:0]  ch_clear_o;
  logic [4:0]  ch_preset_o;
  logic [15:0] counter_ch2_o;
  logic [1:0]  comb_mode_o;
  logic [4:0]  channel_pin_a_o;
  logic [4:0]  channel_pin_a_oe_o;
  logic        irq_o;
  int          bad_count;
  int          cmp_count;
  logic [15:0] cnt_exp;
  logic [31:0] rd;
  logic        err;
  logic [31:0] v;
  logic [4:0]  q;

  tsm_ctrl tsm_ctrl_inst (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .standby_i(standby_i),
    .ch_clear_req_i(ch_clear_req_i), .ch_preset_req_i(ch_preset_req_i),
    .cmp_match_a_i(cmp_match_a_i), .cmp_match_b_i(cmp_match_b_i),
    .ch2_run_i(ch2_run_i), .ch2_tick_i(ch2_tick_i),
    .ch2_preset_val_i(ch2_preset_val_i),
    .ext_clock_in_a_i(ext_clock_in_a_i), .ext_clock_in_b_i(ext_clock_in_b_i),
    .ch_clear_o(ch_clear_o), .ch_preset_o(ch_preset_o),
    .counter_ch2_o(counter_ch2_o), .comb_mode_o(comb_mode_o),
    .channel_pin_a_o(channel_pin_a_o),
    .channel_pin_a_oe_o(channel_pin_a_oe_o), .irq_o(irq_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("tests done: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // whole apb transfer; data taken at the edge where pready is sampled
  // only the watchdog ends a wait for ready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge ref_clk_i);
    end
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, "read");
  endtask

  // one-cycle pulse on the request and compare inputs, checked a cycle on
  task automatic pulse(input logic [4:0] cl, input logic [4:0] pr,
                       input logic [4:0] ma, input logic [4:0] mb);
    @(posedge ref_clk_i);
    ch_clear_req_i  <= cl;
    ch_preset_req_i <= pr;
    cmp_match_a_i   <= ma;
    cmp_match_b_i   <= mb;
    @(posedge ref_clk_i);
    ch_clear_req_i  <= 5'h00;
    ch_preset_req_i <= 5'h00;
    cmp_match_a_i   <= 5'h00;
    cmp_match_b_i   <= 5'h00;
    @(negedge ref_clk_i);
  endtask

  function automatic logic [4:0] sync_exp(input logic [4:0] sy,
                                          input logic [4:0] rq);
    sync_exp = rq | ((|(rq & sy)) ? sy : 5'h00);
  endfunction

  task automatic sync_case(input logic [4:0] sy, input logic [4:0] cl,
                           input logic [4:0] pr);
    apb(1'b1, 8'h00, {27'h000_0000, sy});
    pulse(cl, pr, 5'h00, 5'h00);
    chk({27'h0, ch_clear_o}, {27'h0, sync_exp(sy, cl)}, "clr");
    chk({27'h0, ch_preset_o}, {27'h0, sync_exp(sy, pr)}, "pre");
  endtask

  // one pin change; a tick pulse rides along and must be ignored
  task automatic qstep(input logic a, input logic b, input logic [15:0] d);
    @(posedge ref_clk_i);
    ext_clock_in_a_i <= a;
    ext_clock_in_b_i <= b;
    ch2_tick_i       <= 1'b1;
    @(posedge ref_clk_i);
    ch2_tick_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    cnt_exp = cnt_exp + d;
    @(negedge ref_clk_i);
    chk({16'h0, counter_ch2_o}, {16'h0, cnt_exp}, "cnt");
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {psel_i, penable_i, pwrite_i, standby_i, ch2_tick_i} = 5'h00;
    {ext_clock_in_a_i, ext_clock_in_b_i} = 2'h0;
    {paddr_i, pwdata_i, ch2_preset_val_i} = 56'h0;
    {ch_clear_req_i, ch_preset_req_i, cmp_match_a_i, cmp_match_b_i} = '0;
    ch2_run_i = 1'b1;
    rst_b_i   = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cnt_exp   = 16'h0000;
    void'($urandom(84065));
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rdchk(8'h00, 32'h0000_00e0);
    rdchk(8'h04, 32'h0000_0080);
    rdchk(8'h40, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001, "slverr");
    $display("test reset and map done");
    // random register values and sync fan-out
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      apb(1'b1, 8'h00, v);
      rdchk(8'h00, {24'h0, v[7:0] & 8'h1f | 8'he0});
      apb(1'b1, 8'h04, v & 32'hffff_ffbf);
      rdchk(8'h04, {24'h0, v[7:0] & 8'h3f | 8'h80});
      sync_case(v[4:0], 5'($urandom), 5'($urandom));
    end
    sync_case(5'h00, 5'h04, 5'h11);
    sync_case(5'h1f, 5'h01, 5'h00);
    rdchk(8'h0c, 32'h0000_0002);
    sync_case(5'h0a, 5'h08, 5'h04);
    $display("test sync done");
    // pwm pin behaviour and combination override
    apb(1'b1, 8'h04, 32'h0000_001f);
    repeat (2) @(posedge ref_clk_i);
    chk({27'h0, channel_pin_a_oe_o}, 32'h0000_001f, "oe");
    pulse(5'h00, 5'h00, 5'h1f, 5'h00);
    chk({27'h0, channel_pin_a_o}, 32'h0000_001f, "pin set");
    q = 5'($urandom);
    pulse(5'h00, 5'h00, 5'h00, q);
    chk({27'h0, channel_pin_a_o}, {27'h0, ~q}, "pin clr");
    // combination mode takes pwm pin enable away from channels 3 and 4
    apb(1'b1, 8'h08, 32'h0000_0002);
    repeat (2) @(posedge ref_clk_i);
    chk({30'h0, comb_mode_o}, 32'h0000_0002, "comb");
    chk({27'h0, channel_pin_a_oe_o}, 32'h0000_0007, "oe comb");
    apb(1'b1, 8'h08, 32'h0000_0001);
    repeat (2) @(posedge ref_clk_i);
    chk({27'h0, channel_pin_a_oe_o}, 32'h0000_001f, "oe norm");
    apb(1'b1, 8'h04, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_i);
    chk({27'h0, channel_pin_a_oe_o}, 32'h0000_0000, "oe off");
    $display("test pwm done");
    // phase counting; sync off so the clear hits channel 2 alone
    apb(1'b1, 8'h00, 32'h0000_0000);
    pulse(5'h04, 5'h00, 5'h00, 5'h00);
    cnt_exp = 16'h0000;
    apb(1'b1, 8'h04, 32'h0000_0040);
    qstep(1'b0, 1'b1, 16'h0001);
    qstep(1'b1, 1'b1, 16'h0001);
    qstep(1'b1, 1'b0, 16'h0001);
    qstep(1'b0, 1'b0, 16'h0001);
    qstep(1'b1, 1'b0, 16'hffff);
    qstep(1'b1, 1'b1, 16'hffff);
    qstep(1'b0, 1'b1, 16'hffff);
    qstep(1'b0, 1'b0, 16'hffff);
    $display("test phase done");
    // overflow flag condition and interrupt
    apb(1'b1, 8'h0c, 32'h0000_0003);
    apb(1'b1, 8'h10, 32'h0000_0001);
    qstep(1'b1, 1'b0, 16'hffff);
    rdchk(8'h0c, 32'h0000_0001);
    chk({31'h0, irq_o}, 32'h0000_0001, "irq");
    apb(1'b1, 8'h0c, 32'h0000_0001);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq clr");
    apb(1'b1, 8'h04, 32'h0000_0060);
    qstep(1'b0, 1'b0, 16'h0001);
    rdchk(8'h0c, 32'h0000_0001);
    apb(1'b1, 8'h0c, 32'h0000_0001);
    qstep(1'b1, 1'b0, 16'hffff);
    rdchk(8'h0c, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0000_0000);
    qstep(1'b0, 1'b0, 16'h0001);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq masked");
    $display("test flag done");
    // standby reload
    apb(1'b1, 8'h00, 32'h0000_001f);
    @(posedge ref_clk_i);
    standby_i <= 1'b1;
    @(posedge ref_clk_i);
    standby_i <= 1'b0;
    rdchk(8'h00, 32'h0000_00e0);
    rdchk(8'h04, 32'h0000_0080);
    $display("test standby done");
    finish_test();
  end
endmodule
